// ==== hw/cgr_pkg.sv ====
// Package of constants for the clock generator configuration register bank.
// Operation
// - Byte 2 holds one read-write edge-rate bit per differential output, 0 slow and 1 fast, all resetting to 1.
// - Byte 3 bits 7:6 select the reference edge rate from 0.9 to 1.8 V/ns and reset to 01.
// - Byte 3 bit 5 keeps the reference running in power down (reset 0) and bit 4 enables it (reset 1).
// - Byte 5 is read-only with a fixed revision code in bits 7:4 and a fixed maker code in bits 3:0.
// - Byte 6 is read-only with a fixed type code in bits 7:6 and a fixed device code in bits 5:0.
// - Byte 7 bits 4:0 set the block read length, reset to 8, and bits 7:5 are reserved.
// - A block read after a repeated start returns the length first and then the data bytes.
package cgr_pkg;

  // Register indices on the serial bus.
  localparam logic [7:0] IDX_OUT_ENABLE = 8'h00;
  localparam logic [7:0] IDX_SPREAD     = 8'h01;
  localparam logic [7:0] IDX_EDGE_RATE  = 8'h02;
  localparam logic [7:0] IDX_REF_CTRL   = 8'h03;
  localparam logic [7:0] IDX_RESERVED   = 8'h04;
  localparam logic [7:0] IDX_REV_MAKER  = 8'h05;
  localparam logic [7:0] IDX_TYPE_DEV   = 8'h06;
  localparam logic [7:0] IDX_RD_LENGTH  = 8'h07;

  // Field positions inside the reference control byte.
  localparam int REF_RATE_HI = 7;
  localparam int REF_RATE_LO = 6;
  localparam int REF_KEEP_PD = 5;
  localparam int REF_ENABLE  = 4;

  // Reset values.
  localparam logic [7:0] EDGE_RATE_RST   = 8'hff;
  localparam logic [1:0] REF_RATE_RST    = 2'h1;
  localparam logic       REF_KEEP_PD_RST = 1'b0;
  localparam logic       REF_ENABLE_RST  = 1'b1;
  localparam logic [4:0] RD_LENGTH_RST   = 5'h08;

  // Reserved bits 3:0 of the reference control byte read as ones.
  localparam logic [3:0] REF_RSVD_VALUE  = 4'hf;

  // Serial frame: eight data bits, then the acknowledge slot.
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] ACK_SLOT        = 4'h9;

  // Default seven-bit slave address; the value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR_DEF  = 7'h5b;

  // Transfer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_INDEX  = 3'b011,
    ST_COUNT  = 3'b010,
    ST_WDATA  = 3'b110,
    ST_READ   = 3'b111,
    ST_IGNORE = 3'b101
  } cgr_state_t;

endpackage : cgr_pkg

// ==== hw/cgr_line_edge.sv ====
// Registered copy of one bus line with rise and fall pulses.
`timescale 1ns/10ps
module cgr_line_edge (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic line_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic prev;

  // Idle bus lines are pulled high, so both stages reset to one.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      level <= 1'b1;
      prev  <= 1'b1;
    end else begin
      level <= line_in;
      prev  <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule : cgr_line_edge

// ==== hw/cgr_regs.sv ====
// Serial-bus slave holding the upper configuration registers of the clock generator.
`timescale 1ns/10ps
module cgr_regs #(
  parameter logic [6:0] SLAVE_ADDR    = cgr_pkg::SLAVE_ADDR_DEF,
  parameter logic [3:0] REVISION_CODE = 4'h3, // Arbitrary value.
  parameter logic [3:0] MAKER_CODE    = 4'h6, // Arbitrary value.
  parameter logic [1:0] TYPE_CODE     = 2'h2, // Arbitrary value.
  parameter logic [5:0] DEVICE_CODE   = 6'h15 // Arbitrary value.
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  output logic [7:0]      output_edge_rate_select,
  output logic [1:0]      ref_edge_rate,
  output logic            keep_reference_in_power_down,
  output logic            ref_out_enable,
  output logic [4:0]      block_read_length
);

  logic                scl_level;
  logic                scl_rise;
  logic                scl_fall;
  logic                sda_level;
  logic                sda_rise;
  logic                sda_fall;
  logic                start_seen;
  logic                stop_seen;
  cgr_pkg::cgr_state_t state;
  logic [3:0]          bit_cnt;
  logic [7:0]          rx_shift;
  logic [7:0]          tx_shift;
  logic [7:0]          index;
  logic [7:0]          bytes_left;
  logic                host_ack;
  logic                send_length;
  logic [7:0]          rd_data;
  logic                wr_strobe;

  // Both bus lines pass through the same edge finder.
  cgr_line_edge u_scl (
    .mclk    (mclk),
    .rst     (rst),
    .line_in (scl_in),
    .level   (scl_level),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  cgr_line_edge u_sda (
    .mclk    (mclk),
    .rst     (rst),
    .line_in (sda_in),
    .level   (sda_level),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // A data edge while the clock is high frames a transfer.
  assign start_seen = sda_fall & scl_level;
  assign stop_seen  = sda_rise & scl_level;

  // A data byte lands in a register at the end of its eighth bit.
  assign wr_strobe = scl_fall && (bit_cnt == cgr_pkg::BITS_PER_BYTE) &&
                     (state == cgr_pkg::ST_WDATA) && (bytes_left != 8'h00);

  // Read multiplexer; unmapped indices and the reserved byte read zero.
  always_comb begin
    rd_data = 8'h00;
    if (index == cgr_pkg::IDX_EDGE_RATE) begin
      rd_data = output_edge_rate_select;
    end else if (index == cgr_pkg::IDX_REF_CTRL) begin
      rd_data = {ref_edge_rate, keep_reference_in_power_down,
                 ref_out_enable, cgr_pkg::REF_RSVD_VALUE};
    end else if (index == cgr_pkg::IDX_REV_MAKER) begin
      rd_data = {REVISION_CODE, MAKER_CODE};
    end else if (index == cgr_pkg::IDX_TYPE_DEV) begin
      rd_data = {TYPE_CODE, DEVICE_CODE};
    end else if (index == cgr_pkg::IDX_RD_LENGTH) begin
      rd_data = {3'h0, block_read_length};
    end
  end

  // Bit counter and receive shifter follow the clock edges of the frame.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt  <= 4'h0;
      rx_shift <= 8'h00;
      host_ack <= 1'b0;
    end else if (start_seen || stop_seen) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      if (bit_cnt < cgr_pkg::BITS_PER_BYTE) begin
        rx_shift <= {rx_shift[6:0], sda_level};
      end else begin
        host_ack <= ~sda_level; // Low in the ninth slot means acknowledge.
      end
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_fall && bit_cnt == cgr_pkg::ACK_SLOT) begin
      bit_cnt <= 4'h0;
    end
  end

  // Transfer sequencing, index and remaining byte count.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state       <= cgr_pkg::ST_IDLE;
      index       <= 8'h00;
      bytes_left  <= 8'h00;
      send_length <= 1'b0;
    end else if (start_seen) begin
      state <= cgr_pkg::ST_ADDR; // A repeated start keeps the index.
    end else if (stop_seen) begin
      state <= cgr_pkg::ST_IDLE;
    end else if (scl_fall && bit_cnt == cgr_pkg::BITS_PER_BYTE) begin
      case (state)
        cgr_pkg::ST_ADDR: begin
          if (rx_shift[7:1] != SLAVE_ADDR) begin
            state <= cgr_pkg::ST_IGNORE;
          end else if (rx_shift[0]) begin
            state       <= cgr_pkg::ST_READ;
            send_length <= 1'b1;
          end else begin
            state <= cgr_pkg::ST_INDEX;
          end
        end
        cgr_pkg::ST_INDEX: begin
          index <= rx_shift;
          state <= cgr_pkg::ST_COUNT;
        end
        cgr_pkg::ST_COUNT: begin
          bytes_left <= rx_shift;
          state      <= cgr_pkg::ST_WDATA;
        end
        cgr_pkg::ST_WDATA: begin
          if (bytes_left != 8'h00) begin
            index      <= index + 8'h01;
            bytes_left <= bytes_left - 8'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall && bit_cnt == cgr_pkg::ACK_SLOT &&
                 state == cgr_pkg::ST_READ) begin
      // Length goes out first, then data while the host keeps acknowledging.
      if (send_length) begin
        send_length <= 1'b0;
        bytes_left  <= {3'h0, block_read_length};
      end else if (host_ack && bytes_left != 8'h00) begin
        index      <= index + 8'h01;
        bytes_left <= bytes_left - 8'h01;
      end else begin
        state <= cgr_pkg::ST_IGNORE; // Not acknowledged or run out.
      end
    end
  end

  // Open-drain data drive: low only, released at every frame boundary.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_oe   <= 1'b0;
      tx_shift <= 8'h00;
    end else if (start_seen || stop_seen) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt == cgr_pkg::BITS_PER_BYTE) begin
        // Every byte addressed to us is acknowledged, even ignored ones.
        sda_oe <= (state == cgr_pkg::ST_ADDR) ?
                  (rx_shift[7:1] == SLAVE_ADDR) :
                  (state == cgr_pkg::ST_INDEX || state == cgr_pkg::ST_COUNT ||
                   state == cgr_pkg::ST_WDATA);
      end else if (bit_cnt == cgr_pkg::ACK_SLOT) begin
        if (state == cgr_pkg::ST_READ && send_length) begin
          // The length byte is {000, length}, so its first bit pulls low.
          tx_shift <= {2'h0, block_read_length, 1'b0};
          sda_oe   <= 1'b1;
        end else if (state == cgr_pkg::ST_READ && host_ack &&
                     bytes_left != 8'h00) begin
          tx_shift <= {rd_data[6:0], 1'b0};
          sda_oe   <= ~rd_data[7];
        end else begin
          sda_oe <= 1'b0;
        end
      end else if (state == cgr_pkg::ST_READ && bit_cnt != 4'h0) begin
        // Shift the next bit out while the clock is low.
        sda_oe   <= ~tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  // The data line is never driven high; it is pulled up outside.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Output edge-rate selects, one bit per differential output.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      output_edge_rate_select <= cgr_pkg::EDGE_RATE_RST;
    end else if (wr_strobe && index == cgr_pkg::IDX_EDGE_RATE) begin
      output_edge_rate_select <= rx_shift;
    end
  end

  // Reference output controls; reserved low nibble is not stored.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ref_edge_rate                <= cgr_pkg::REF_RATE_RST;
      keep_reference_in_power_down <= cgr_pkg::REF_KEEP_PD_RST;
      ref_out_enable               <= cgr_pkg::REF_ENABLE_RST;
    end else if (wr_strobe && index == cgr_pkg::IDX_REF_CTRL) begin
      ref_edge_rate <= rx_shift[cgr_pkg::REF_RATE_HI:cgr_pkg::REF_RATE_LO];
      keep_reference_in_power_down <= rx_shift[cgr_pkg::REF_KEEP_PD];
      ref_out_enable <= rx_shift[cgr_pkg::REF_ENABLE];
    end
  end

  // Block read length; upper reserved bits are dropped on write.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      block_read_length <= cgr_pkg::RD_LENGTH_RST;
    end else if (wr_strobe && index == cgr_pkg::IDX_RD_LENGTH) begin
      block_read_length <= rx_shift[4:0];
    end
  end

endmodule : cgr_regs

// ==== test/cgr_regs_properties.sv ====
// Checker for the configuration register bank ports.
`timescale 1ns/10ps
module cgr_regs_properties (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [7:0] output_edge_rate_select,
  input wire logic [1:0] ref_edge_rate,
  input wire logic       keep_reference_in_power_down,
  input wire logic       ref_out_enable,
  input wire logic [4:0] block_read_length
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Values seen at the first edge after reset is released.
  a_reset_values: assert property ($past(rst) |->
    output_edge_rate_select == 8'hff && ref_edge_rate == 2'h1 &&
    !keep_reference_in_power_down && ref_out_enable &&
    block_read_length == 5'h08) else $error("reset values wrong");
  // Stores land on the second mclk edge after a bus clock fall, never mid-bit.
  a_edge_update: assert property ($changed(output_edge_rate_select)
    |-> !scl_in && !$past(scl_in, 2)) else $error("edge select moved");
  a_rate_update: assert property ($changed(ref_edge_rate)
    |-> !scl_in && !$past(scl_in, 2)) else $error("ref rate moved");
  a_ref_update: assert property ($changed({keep_reference_in_power_down,
    ref_out_enable}) |-> !scl_in && !$past(scl_in, 2))
    else $error("ref control moved");
  a_length_update: assert property ($changed(block_read_length)
    |-> !scl_in && !$past(scl_in, 2)) else $error("length moved");
  // The device may only move the data line while the bus clock is low.
  a_drive_scl_low: assert property ($changed(sda_oe)
    |-> !scl_in && !$past(scl_in, 2)) else $error("data moved in high");
  a_drive_holds: assert property ($rose(scl_in)
    |=> $stable(sda_oe) [*4]) else $error("data not held");
  a_pull_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  c_sel_write: cover property ($changed(output_edge_rate_select));
  c_len_write: cover property ($changed(block_read_length));
  c_dev_drive: cover property ($rose(sda_oe));
endmodule : cgr_regs_properties
bind cgr_regs cgr_regs_properties cgr_regs_properties_inst (.mclk, .rst,
  .scl_in, .sda_out, .sda_oe, .output_edge_rate_select, .ref_edge_rate,
  .keep_reference_in_power_down, .ref_out_enable, .block_read_length);

// ==== test/cgr_host.sv ====
// Bus host model making open-drain block transfers, 14 mclk per bit.
`timescale 1ns/10ps
module cgr_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  // Lines rest high between frames; the clock stands still there.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask : gap
  // Data moves two cycles after scl falls so it is never seen as a stop.
  task automatic clk_bit(input logic b, output logic r);
    sda_pull = ~b;
    gap(6);
    scl = 1'b1;
    gap(3);
    r = sda;
    gap(3);
    scl = 1'b0;
    gap(2);
  endtask : clk_bit
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    sda_pull = 1'b0;
    gap(6);
    scl = 1'b1;
    gap(6);
    sda_pull = 1'b1;
    gap(6);
    scl = 1'b0;
    gap(2);
  endtask : start
  task automatic stop();
    sda_pull = 1'b1;
    gap(6);
    scl = 1'b1;
    gap(6);
    sda_pull = 1'b0;
    gap(6);
  endtask : stop
  // Byte out MSB first; the ninth slot returns the acknowledge level.
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], r);
    clk_bit(1'b1, ack);
  endtask : wr_byte
  // Host acks each byte read and not-acks the last one.
  task automatic rd_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      v[i] = r;
    end
    clk_bit(last, r);
  endtask : rd_byte
endmodule : cgr_host

// ==== test/cgr_regs_tb.sv ====
// Self-checking bench for the configuration register bank.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  fail_count++; $display("mismatch %s expected %h seen %h", nm, exp, got); \
  end end
module cgr_regs_tb;
  localparam logic [6:0] ADDR  = 7'h5b;
  localparam logic [3:0] REV   = 4'ha; // Arbitrary value.
  localparam logic [3:0] MAKER = 4'h5; // Arbitrary value.
  localparam logic [1:0] DTYPE = 2'h1; // Arbitrary value.
  localparam logic [5:0] DEV   = 6'h2c; // Arbitrary value.
  logic       mclk, rst, scl, sda_pull, sda, sda_out, sda_oe, keep, ena, ack;
  logic [7:0] sel, d;
  logic [1:0] rate;
  logic [4:0] len;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  // Open-drain data line with a pull-up.
  assign sda = ~(sda_pull | sda_oe);
  // Identity codes are set here so the expected bytes do not lean on defaults.
  cgr_regs #(.SLAVE_ADDR(ADDR), .REVISION_CODE(REV), .MAKER_CODE(MAKER),
    .TYPE_CODE(DTYPE), .DEVICE_CODE(DEV)) cgr_regs_inst (.mclk(mclk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .output_edge_rate_select(sel), .ref_edge_rate(rate),
    .keep_reference_in_power_down(keep), .ref_out_enable(ena),
    .block_read_length(len));
  cgr_host cgr_host_inst (.mclk(mclk), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // The whole run needs about 6000 cycles; a hang stops well after.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] b);
    cgr_host_inst.wr_byte(b, ack);
    `CHK("ack", 1'b0, ack)
  endtask : wr
  task automatic blk_wr(input logic [7:0] idx, input logic [7:0] q[$]);
    cgr_host_inst.start();
    wr({ADDR, 1'b0});
    wr(idx);
    wr(8'(q.size()));
    foreach (q[i]) wr(q[i]);
    cgr_host_inst.stop();
  endtask : blk_wr
  // Expected queue starts with the length byte the device sends first.
  task automatic blk_rd(input logic [7:0] idx, input logic [7:0] q[$]);
    cgr_host_inst.start();
    wr({ADDR, 1'b0});
    wr(idx);
    cgr_host_inst.start();
    wr({ADDR, 1'b1});
    foreach (q[i]) begin
      cgr_host_inst.rd_byte(i == q.size() - 1, d);
      `CHK("read byte", q[i], d)
    end
    cgr_host_inst.stop();
  endtask : blk_rd
  task automatic t_reset();
    `CHK("edge select", 8'hff, sel)
    `CHK("ref rate", 2'h1, rate)
    `CHK("keep", 1'b0, keep)
    `CHK("enable", 1'b1, ena)
    `CHK("length", 5'h08, len)
    $display("test reset done");
  endtask : t_reset
  task automatic t_write();
    blk_wr(8'h02, '{8'h5a});
    `CHK("edge select", 8'h5a, sel)
    $display("test write done");
  endtask : t_write
  // Every rate code, with keep and enable toggled against each other.
  task automatic t_ref();
    for (int k = 0; k < 4; k++) begin
      blk_wr(8'h03, '{{2'(k), k[0], ~k[0], 4'h0}});
      `CHK("ref rate", 2'(k), rate)
      `CHK("keep", k[0], keep)
      `CHK("enable", ~k[0], ena)
    end
    $display("test ref done");
  endtask : t_ref
  // Reserved and read-only bytes are acked but only the length sticks.
  task automatic t_ro();
    // A frame for another address is left unanswered.
    cgr_host_inst.start();
    cgr_host_inst.wr_byte({ADDR ^ 7'h01, 1'b0}, ack);
    `CHK("foreign ack", 1'b1, ack)
    cgr_host_inst.stop();
    blk_wr(8'h04, '{8'hff, 8'h00, 8'h00, 8'he4});
    `CHK("length", 5'h04, len)
    $display("test readonly done");
  endtask : t_ro
  task automatic t_read();
    blk_rd(8'h02, '{8'h04, 8'h5a, 8'hef, 8'h00, {REV, MAKER}});
    blk_rd(8'h06, '{8'h04, {DTYPE, DEV}, 8'h04, 8'h00, 8'h00});
    $display("test read done");
  endtask : t_read
  initial begin
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (3) @(negedge mclk);
    t_reset();
    t_write();
    t_ref();
    t_ro();
    t_read();
    conclude();
  end
endmodule : cgr_regs_tb
